/* File: hw/icp_slave.sv */
`timescale 1ns/1ps

// Write-stream buffer; DEPTH must be a power of two
module icp_fifo
	import icp_pkg::*;
#(
	parameter int W     = ICP_FIFO_W,
	parameter int DEPTH = ICP_FIFO_DEPTH
) (
	input  wire logic         ref_clk,
	input  wire logic         reset_n,
	input  wire logic         ce,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
		logic                    full;
		logic                    nempty;
	} icp_fifo_t;

	icp_fifo_t f_r;
	icp_fifo_t f_nxt;
	logic      push;
	logic      pop;

	assign push      = in_valid && !f_r.full;
	assign pop       = out_ready && f_r.nempty;
	assign in_ready  = !f_r.full;
	assign out_valid = f_r.nempty;
	assign out_data  = f_r.mem[f_r.rp];

	// Flags are registered so both handshakes come from flops
	always_comb begin
		f_nxt = f_r;
		if (push) begin
			f_nxt.mem[f_r.wp] = in_data;
			f_nxt.wp          = AW'(f_r.wp + 1'b1);
		end
		if (pop)
			f_nxt.rp = AW'(f_r.rp + 1'b1);
		if (push && !pop)
			f_nxt.cnt = (AW+1)'(f_r.cnt + 1'b1);
		else if (pop && !push)
			f_nxt.cnt = (AW+1)'(f_r.cnt - 1'b1);
		f_nxt.full   = (f_nxt.cnt == (AW+1)'(DEPTH));
		f_nxt.nempty = (f_nxt.cnt != '0);
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			f_r <= '0;
		else if (ce)
			f_r <= f_nxt;
	end
endmodule

// Device end: bus slave that keeps the command pointer
module icp_slave
	import icp_pkg::*;
#(
	parameter int FIFO_DEPTH = ICP_FIFO_DEPTH
) (
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	input  wire logic       ce,
	icp_bus_if.slave        bus,
	input  wire logic [1:0] addr_select_pin_first,
	input  wire logic [1:0] addr_select_pin_second,
	input  wire logic [1:0] addr_select_pin_third,
	output logic [7:0]      rd_addr,
	input  wire logic [7:0] rd_data,
	output logic            wr_valid,
	input  wire logic       wr_ready,
	output logic [7:0]      wr_reg,
	output logic [7:0]      wr_byte
);
	typedef struct packed {
		logic [2:0]  scl_q;
		logic [2:0]  sda_q;
		logic [5:0]  tie_q1;
		logic [5:0]  tie_q2;
		icp_sst_t    st;
		icp_phase_t  phase;
		logic        rw;
		logic        nack;
		logic [3:0]  cnt;
		logic [7:0]  sh;
		logic [7:0]  ptr;
		logic        sda_oe;
		logic        scl_oe;
		logic        push;
		logic [15:0] push_data;
	} icp_sreg_t;

	icp_sreg_t  s_r;
	icp_sreg_t  s_nxt;
	logic       fifo_in_ready;
	logic [15:0] fifo_out;
	logic       scl_rise;
	logic       scl_fall;
	logic       bus_start;
	logic       bus_stop;
	logic [6:0] own_addr;
	logic [1:0] t_first;
	logic [1:0] t_second;
	logic [1:0] t_third;

	// Edges read only the second and third sync stages
	assign scl_rise  = s_r.scl_q[1] && !s_r.scl_q[2];
	assign scl_fall  = !s_r.scl_q[1] && s_r.scl_q[2];
	assign bus_start = s_r.scl_q[1] && s_r.scl_q[2] && !s_r.sda_q[1] && s_r.sda_q[2];
	assign bus_stop  = s_r.scl_q[1] && s_r.scl_q[2] && s_r.sda_q[1] && !s_r.sda_q[2];

	assign t_first  = s_r.tie_q2[1:0];
	assign t_second = s_r.tie_q2[3:2];
	assign t_third  = s_r.tie_q2[5:4];

	assign own_addr = {t_third[ICP_TIE_BUS], !t_second[ICP_TIE_BUS], t_second[ICP_TIE_BUS],
		t_first[ICP_TIE_BUS], t_third[ICP_TIE_HI], t_second[ICP_TIE_HI], t_first[ICP_TIE_HI]};

	assign bus.d_sda_oe = s_r.sda_oe;
	assign bus.d_scl_oe = s_r.scl_oe;
	assign rd_addr      = s_r.ptr;
	assign wr_reg       = fifo_out[15:8];
	assign wr_byte      = fifo_out[7:0];

	// Byte engine, stepped by synchronised bus edges
	always_comb begin
		s_nxt        = s_r;
		s_nxt.scl_q  = {s_r.scl_q[1:0], bus.scl};
		s_nxt.sda_q  = {s_r.sda_q[1:0], bus.sda};
		s_nxt.tie_q1 = {addr_select_pin_third, addr_select_pin_second, addr_select_pin_first};
		s_nxt.tie_q2 = s_r.tie_q1;
		if (s_r.push && fifo_in_ready)
			s_nxt.push = 1'b0;
		if (bus_stop && s_r.st != ICP_S_HOLD) begin
			s_nxt.st     = ICP_S_IDLE;
			s_nxt.sda_oe = 1'b0;
		end else if (bus_start && s_r.st != ICP_S_HOLD) begin
			s_nxt.st     = ICP_S_RX;
			s_nxt.phase  = ICP_PH_ADDR;
			s_nxt.cnt    = 4'h0;
			s_nxt.sda_oe = 1'b0;
		end else begin
			case (s_r.st)
				ICP_S_RX: begin
					if (scl_rise && s_r.cnt < ICP_BYTE_BITS) begin
						s_nxt.sh  = {s_r.sh[6:0], s_r.sda_q[1]};
						s_nxt.cnt = 4'(s_r.cnt + 4'h1);
					end else if (scl_fall && s_r.cnt == ICP_BYTE_BITS) begin
						case (s_r.phase)
							ICP_PH_ADDR: begin
								if (s_r.sh[7:1] == own_addr) begin
									s_nxt.rw     = s_r.sh[0];
									s_nxt.sda_oe = 1'b1;
									s_nxt.st     = ICP_S_ACK;
								end else begin
									s_nxt.st = ICP_S_IDLE;
								end
							end
							ICP_PH_CMD: begin
								s_nxt.ptr    = s_r.sh;
								s_nxt.sda_oe = 1'b1;
								s_nxt.st     = ICP_S_ACK;
							end
							default: begin
								s_nxt.push      = 1'b1;
								s_nxt.push_data = {s_r.ptr, s_r.sh};
								s_nxt.sda_oe    = 1'b1;
								s_nxt.scl_oe    = 1'b1;
								s_nxt.st        = ICP_S_HOLD;
							end
						endcase
					end
				end
				ICP_S_HOLD: begin
					// Clock is held low until the buffer takes the byte
					if (s_r.push && fifo_in_ready) begin
						s_nxt.scl_oe = 1'b0;
						s_nxt.ptr    = icp_next_ptr(s_r.ptr);
						s_nxt.st     = ICP_S_ACK;
					end
				end
				ICP_S_ACK: begin
					if (scl_fall) begin
						s_nxt.cnt = 4'h0;
						if (s_r.phase == ICP_PH_ADDR && s_r.rw) begin
							s_nxt.sh     = rd_data;
							s_nxt.sda_oe = !rd_data[7];
							s_nxt.st     = ICP_S_TX;
						end else begin
							s_nxt.sda_oe = 1'b0;
							s_nxt.phase  = (s_r.phase == ICP_PH_ADDR) ? ICP_PH_CMD : ICP_PH_DATA;
							s_nxt.st     = ICP_S_RX;
						end
					end
				end
				ICP_S_TX: begin
					if (scl_fall) begin
						if (s_r.cnt == 4'h7) begin
							s_nxt.sda_oe = 1'b0;
							s_nxt.st     = ICP_S_TXACK;
						end else begin
							s_nxt.cnt    = 4'(s_r.cnt + 4'h1);
							s_nxt.sh     = {s_r.sh[6:0], 1'b0};
							s_nxt.sda_oe = !s_r.sh[6];
						end
					end
				end
				ICP_S_TXACK: begin
					if (scl_rise) begin
						s_nxt.nack = s_r.sda_q[1];
						s_nxt.ptr  = icp_next_ptr(s_r.ptr);
					end else if (scl_fall) begin
						if (s_r.nack) begin
							s_nxt.st = ICP_S_IDLE;
						end else begin
							// Next byte comes from the advanced pointer
							s_nxt.sh     = rd_data;
							s_nxt.cnt    = 4'h0;
							s_nxt.sda_oe = !rd_data[7];
							s_nxt.st     = ICP_S_TX;
						end
					end
				end
				default: begin
					s_nxt.sda_oe = 1'b0;
					s_nxt.scl_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			s_r <= '0;
		else if (ce)
			s_r <= s_nxt;
	end

	// Write stream buffer; a full buffer stretches the bus clock
	icp_fifo #(.W(ICP_FIFO_W), .DEPTH(FIFO_DEPTH)) i_icp_fifo (
		.ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .in_valid(s_r.push),
		.in_ready(fifo_in_ready), .in_data(s_r.push_data), .out_valid(wr_valid),
		.out_ready(wr_ready), .out_data(fifo_out)
	);
endmodule

/* File: hw/icp_pkg.sv */
package icp_pkg;

	// Reference clock and bus bit timing (one quarter of a 100 kHz bit)
	localparam int ICP_CLK_KHZ = 25000;
	localparam int ICP_QTR_NS  = 2500;
	// Least time, so round up to whole cycles
	localparam int ICP_QTR_CYC = (ICP_QTR_NS * ICP_CLK_KHZ + 999999) / 1000000;

	// Write stream buffer: {pointer, data} words
	localparam int ICP_FIFO_W     = 16;
	localparam int ICP_FIFO_DEPTH = 16;

	// Select-pin tie codes: bit 1 = tied to a bus line, bit 0 = tied high (supply or data)
	localparam logic [1:0] ICP_TIE_GND = 2'h0;
	localparam logic [1:0] ICP_TIE_VDD = 2'h1;
	localparam logic [1:0] ICP_TIE_SCL = 2'h2;
	localparam logic [1:0] ICP_TIE_SDA = 2'h3;
	localparam int         ICP_TIE_BUS = 1;
	localparam int         ICP_TIE_HI  = 0;

	// Pointer groups
	localparam logic [7:0] ICP_PTR_RESET   = 8'h00;
	localparam logic [7:0] ICP_PTR_FIX_LO  = 8'h0e;
	localparam logic [7:0] ICP_PTR_GRP_LO  = 8'h10;
	localparam logic [7:0] ICP_PTR_GRP_HI  = 8'h17;

	// Bits in a byte before the acknowledge slot
	localparam logic [3:0] ICP_BYTE_BITS = 4'h8;

	typedef enum logic [2:0] {
		ICP_S_IDLE  = 3'b000,
		ICP_S_RX    = 3'b001,
		ICP_S_HOLD  = 3'b010,
		ICP_S_ACK   = 3'b011,
		ICP_S_TX    = 3'b100,
		ICP_S_TXACK = 3'b101
	} icp_sst_t;

	typedef enum logic [1:0] {
		ICP_PH_ADDR = 2'b00,
		ICP_PH_CMD  = 2'b01,
		ICP_PH_DATA = 2'b10
	} icp_phase_t;

	typedef enum logic [1:0] {
		ICP_M_IDLE  = 2'b00,
		ICP_M_START = 2'b01,
		ICP_M_BIT   = 2'b10,
		ICP_M_STOP  = 2'b11
	} icp_mst_t;

	typedef enum logic [1:0] {
		ICP_OP_START = 2'b00,
		ICP_OP_WRITE = 2'b01,
		ICP_OP_READ  = 2'b10,
		ICP_OP_STOP  = 2'b11
	} icp_op_t;

	// Pointer advance: pairs toggle, 0x0e/0x0f stay, 0x10..0x17 wrap upward
	function automatic logic [7:0] icp_next_ptr(input logic [7:0] p);
		if (p < ICP_PTR_FIX_LO)
			return p ^ 8'h01;
		else if (p < ICP_PTR_GRP_LO)
			return p;
		else if (p <= ICP_PTR_GRP_HI)
			return {p[7:3], 3'(p[2:0] + 3'h1)};
		else
			return p;
	endfunction

endpackage

/* File: hw/icp_bus_if.sv */
`timescale 1ns/1ps
// Open-drain two-wire bus: a line is low while any party enables its driver
interface icp_bus_if;
	logic m_scl_oe;
	logic m_sda_oe;
	logic d_scl_oe;
	logic d_sda_oe;
	logic scl;
	logic sda;

	// Wired-AND with pull-ups
	assign scl = !(m_scl_oe || d_scl_oe);
	assign sda = !(m_sda_oe || d_sda_oe);

	modport master (output m_scl_oe, output m_sda_oe, input scl, input sda);
	modport slave  (output d_scl_oe, output d_sda_oe, input scl, input sda);
endinterface

/* File: hw/icp_master.sv */
`timescale 1ns/1ps
// Far end: byte-level bus master driven by a simple op port
module icp_master
	import icp_pkg::*;
#(
	parameter int QTR = ICP_QTR_CYC
) (
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	input  wire logic       ce,
	icp_bus_if.master       bus,
	input  wire logic       op_valid,
	output logic            op_ready,
	input  wire logic [1:0] op_code,
	input  wire logic [7:0] op_data,
	input  wire logic       op_last,
	output logic            rsp_valid,
	output logic [7:0]      rsp_data,
	output logic            rsp_nack
);
	localparam int TW = $clog2(QTR + 1);
	localparam logic [TW-1:0] TQ = TW'(QTR - 1);

	typedef struct packed {
		logic [1:0]    scl_q;
		logic [1:0]    sda_q;
		icp_mst_t      st;
		logic [1:0]    ph;
		logic [3:0]    cnt;
		logic [TW-1:0] tmr;
		logic [7:0]    sh;
		logic          rd;
		logic          last;
		logic          nack;
		logic          scl_oe;
		logic          sda_oe;
		logic          ready;
		logic          rsp_valid;
		logic [7:0]    rsp_data;
		logic          rsp_nack;
	} icp_mreg_t;

	icp_mreg_t m_r;
	icp_mreg_t m_nxt;
	logic      tick;
	logic      scl_hi;

	assign tick         = (m_r.tmr == '0);
	assign scl_hi       = m_r.scl_q[1];
	assign bus.m_scl_oe = m_r.scl_oe;
	assign bus.m_sda_oe = m_r.sda_oe;
	assign op_ready     = m_r.ready;
	assign rsp_valid    = m_r.rsp_valid;
	assign rsp_data     = m_r.rsp_data;
	assign rsp_nack     = m_r.rsp_nack;

	// Each bit is four quarter steps; a high clock waits out slave stretching
	always_comb begin
		m_nxt           = m_r;
		m_nxt.scl_q     = {m_r.scl_q[0], bus.scl};
		m_nxt.sda_q     = {m_r.sda_q[0], bus.sda};
		m_nxt.rsp_valid = 1'b0;
		if (!tick)
			m_nxt.tmr = TW'(m_r.tmr - 1'b1);
		case (m_r.st)
			ICP_M_IDLE: begin
				m_nxt.ready = 1'b1;
				if (op_valid && m_r.ready) begin
					m_nxt.ready = 1'b0;
					m_nxt.ph    = 2'h0;
					m_nxt.cnt   = 4'h0;
					m_nxt.tmr   = TQ;
					m_nxt.sh    = op_data;
					m_nxt.last  = op_last;
					m_nxt.rd    = (op_code == ICP_OP_READ);
					case (op_code)
						ICP_OP_START: m_nxt.st = ICP_M_START;
						ICP_OP_WRITE,
						ICP_OP_READ:  m_nxt.st = ICP_M_BIT;
						default:      m_nxt.st = ICP_M_STOP;
					endcase
				end
			end
			ICP_M_START: begin
				if (tick) begin
					m_nxt.tmr = TQ;
					case (m_r.ph)
						2'h0: begin
							m_nxt.sda_oe = 1'b0;
							m_nxt.ph     = 2'h1;
						end
						2'h1: begin
							m_nxt.scl_oe = 1'b0;
							m_nxt.ph     = 2'h2;
						end
						2'h2: begin
							if (scl_hi) begin
								m_nxt.sda_oe = 1'b1;
								m_nxt.ph     = 2'h3;
							end else begin
								m_nxt.tmr = '0;
							end
						end
						default: begin
							m_nxt.scl_oe = 1'b1;
							m_nxt.st     = ICP_M_BIT;
							m_nxt.ph     = 2'h0;
						end
					endcase
				end
			end
			ICP_M_BIT: begin
				if (tick) begin
					m_nxt.tmr = TQ;
					case (m_r.ph)
						2'h0: begin
							// direction bit sent as data bit 0
							if (m_r.cnt < ICP_BYTE_BITS)
								m_nxt.sda_oe = !m_r.rd && !m_r.sh[7];
							else
								m_nxt.sda_oe = m_r.rd && !m_r.last;
							m_nxt.ph = 2'h1;
						end
						2'h1: begin
							m_nxt.scl_oe = 1'b0;
							m_nxt.ph     = 2'h2;
						end
						2'h2: begin
							if (!scl_hi) begin
								m_nxt.tmr = '0;
							end else begin
								if (m_r.cnt < ICP_BYTE_BITS)
									m_nxt.sh = {m_r.sh[6:0], m_r.sda_q[1]};
								else
									m_nxt.nack = m_r.sda_q[1];
								m_nxt.ph = 2'h3;
							end
						end
						default: begin
							m_nxt.scl_oe = 1'b1;
							m_nxt.ph     = 2'h0;
							if (m_r.cnt == ICP_BYTE_BITS) begin
								m_nxt.st        = ICP_M_IDLE;
								m_nxt.rsp_valid = 1'b1;
								m_nxt.rsp_data  = m_r.sh;
								m_nxt.rsp_nack  = m_r.nack;
							end else begin
								m_nxt.cnt = 4'(m_r.cnt + 4'h1);
							end
						end
					endcase
				end
			end
			default: begin
				if (tick) begin
					m_nxt.tmr = TQ;
					case (m_r.ph)
						2'h0: begin
							m_nxt.sda_oe = 1'b1;
							m_nxt.ph     = 2'h1;
						end
						2'h1: begin
							m_nxt.scl_oe = 1'b0;
							m_nxt.ph     = 2'h2;
						end
						2'h2: begin
							if (scl_hi) begin
								m_nxt.sda_oe = 1'b0;
								m_nxt.ph     = 2'h3;
							end else begin
								m_nxt.tmr = '0;
							end
						end
						default: begin
							m_nxt.st        = ICP_M_IDLE;
							m_nxt.rsp_valid = 1'b1;
							m_nxt.rsp_nack  = 1'b0;
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			m_r <= '0;
		else if (ce)
			m_r <= m_nxt;
	end
endmodule

/* File: tb/icp_checker.sv */
`timescale 1ns/1ps
// Watches the shared two-wire lines where both ends are design code
module icp_checker (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic m_scl_oe,
	input wire logic m_sda_oe,
	input wire logic d_scl_oe,
	input wire logic d_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	// Slave data and ack only move while the clock is low
	slave_setup_a: assert property ($changed(d_sda_oe) |-> !scl)
		else $error("slave moved data with clock high");
	// Stretch only extends a low phase the master began
	stretch_low_a: assert property ($rose(d_scl_oe) |-> !$past(scl) && !scl)
		else $error("slave pulled clock during high phase");
	// A stretch must end; the buffer drains in bounded time
	stretch_end_a: assert property ($rose(d_scl_oe) |-> ##[1:1000] !d_scl_oe)
		else $error("clock held too long");
	// High phase lasts at least one quarter of eight cycles
	high_time_a: assert property ($rose(scl) |-> scl [*8])
		else $error("clock high phase too short");
	// Slave ack or driven-low read bit stays put for the first eight cycles of the high phase
	ack_hold_a: assert property ($rose(scl) && d_sda_oe |-> d_sda_oe [*8])
		else $error("slave data changed in high phase");
	// Master data stays put early in the high phase
	mst_hold_a: assert property ($rose(scl) |-> $stable(m_sda_oe) [*4])
		else $error("master data changed in high phase");
	// Only the master may make a start condition
	start_src_a: assert property ($fell(sda) && scl && $past(scl) |-> m_sda_oe)
		else $error("start not made by master");
	// After a stop the slave keeps the data line free
	stop_free_a: assert property (scl && $rose(sda) |=> !d_sda_oe [*4])
		else $error("slave drove data after stop");

	cover property ($rose(d_sda_oe));
	cover property ($rose(d_scl_oe));
	cover property (scl && $fell(sda));
	cover property (scl && $rose(sda));
endmodule

/* File: tb/icp_tb_top.sv */
`timescale 1ns/1ps
`define chk(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; \
	$display("[FAIL] %0t got %h want %h", $time, (a), (e)); end end

// Both ends face each other; a reference model checks every written word, read byte and end pointer
module i2c_slave_command_pointer_tb_top;
	localparam int T = 5000;
	logic        ref_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        op_valid = 1'b0;
	logic        op_last = 1'b0;
	logic        wr_ready = 1'b0;
	logic        stall = 1'b0;
	logic        rdy;
	logic        nak;
	logic [1:0]  op_code = 2'h0;
	logic [1:0]  p1 = 2'h0;
	logic [1:0]  p2 = 2'h0;
	logic [1:0]  p3 = 2'h0;
	logic [6:0]  dev;
	logic [7:0]  op_data = 8'h00;
	logic [7:0]  rd_data = 8'h00;
	logic [7:0]  ptr = 8'h00;
	logic [7:0]  got;
	logic [7:0]  wd;
	logic [15:0] ew;
	logic        op_ready;
	logic        rsp_valid;
	logic        rsp_nack;
	logic        wr_valid;
	logic [7:0]  rsp_data;
	logic [7:0]  rd_addr;
	logic [7:0]  wr_reg;
	logic [7:0]  wr_byte;
	logic [7:0]  regs [256];
	logic [7:0]  mdl [256];
	logic [15:0] exp_q [$];
	logic [7:0]  starts [10] = '{8'h00, 8'h02, 8'h04, 8'h07, 8'h0a, 8'h0e, 8'h0f, 8'h10,
		8'h15, 8'h17};
	int          err_count = 0;
	int          check_count = 0;

	icp_bus_if bus ();
	icp_master #(.QTR(8)) i_icp_master (.ref_clk(ref_clk), .reset_n(reset_n), .ce(1'b1),
		.bus(bus), .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code),
		.op_data(op_data), .op_last(op_last), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_nack(rsp_nack));
	icp_slave i_icp_slave (.ref_clk(ref_clk), .reset_n(reset_n), .ce(1'b1), .bus(bus),
		.addr_select_pin_first(p1), .addr_select_pin_second(p2), .addr_select_pin_third(p3),
		.rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.wr_reg(wr_reg), .wr_byte(wr_byte));
	icp_checker i_icp_checker (.ref_clk(ref_clk), .reset_n(reset_n), .m_scl_oe(bus.m_scl_oe),
		.m_sda_oe(bus.m_sda_oe), .d_scl_oe(bus.d_scl_oe), .d_sda_oe(bus.d_sda_oe),
		.scl(bus.scl), .sda(bus.sda));

	// 25 MHz reference
	initial forever #20 ref_clk = !ref_clk;

	// Register bank behind the slave; random drain stalls exercise the buffer.
	// The pop for the next rising edge is decided here, so the buffer outputs
	// are never sampled on the edge that launches them.
	always @(negedge ref_clk) begin
		rdy = !stall && ($urandom % 4 != 0);
		if (wr_valid && rdy) begin
			ew = exp_q.size() ? exp_q.pop_front() : 16'hxxxx;
			`chk({wr_reg, wr_byte}, ew)
			regs[wr_reg] = wr_byte;
		end
		wr_ready <= rdy;
		rd_data <= regs[rd_addr];
	end

	// pointer advance, wrapping inside each group
	function automatic logic [7:0] nxt(input logic [7:0] p);
		if (p < 8'h0e)
			return p ^ 8'h01;
		if (p >= 8'h10 && p <= 8'h17)
			return {5'h02, p[2:0] + 3'h1};
		return p;
	endfunction

	// expected address from the tie codes
	function automatic logic [6:0] dec(input logic [1:0] a, input logic [1:0] b,
		input logic [1:0] c);
		return {c[1], !b[1], b[1], a[1], c[0], b[0], a[0]};
	endfunction

	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic tmo(input int n);
		if (n >= T) begin
			err_count++;
			$display("[FAIL] %0t wait ran out", $time);
			end_of_test();
		end
	endtask

	// One op; request held until a clock edge takes it, then wait for the answer
	task automatic op(input logic [1:0] c, input logic [7:0] d, input logic l);
		int n;
		@(negedge ref_clk);
		op_valid = 1'b1;
		op_code = c;
		op_data = d;
		op_last = l;
		for (n = 0; op_ready !== 1'b1 && n < T; n++)
			@(negedge ref_clk);
		tmo(n);
		@(negedge ref_clk);
		op_valid = 1'b0;
		for (n = 0; rsp_valid !== 1'b1 && n < T; n++)
			@(negedge ref_clk);
		tmo(n);
		got = rsp_data;
		nak = rsp_nack;
	endtask

	// address, pointer byte, then n random data bytes
	task automatic wr(input logic [7:0] cmd, input int n, input logic stop);
		op(2'h0, {dev, 1'b0}, 1'b0);
		`chk(nak, 1'b0)
		op(2'h1, cmd, 1'b0);
		ptr = cmd;
		repeat (n) begin
			wd = 8'($urandom);
			exp_q.push_back({ptr, wd});
			mdl[ptr] = wd;
			ptr = nxt(ptr);
			op(2'h1, wd, 1'b0);
			`chk(nak, 1'b0)
		end
		if (stop)
			op(2'h3, 8'h00, 1'b0);
		`chk(rd_addr, ptr)
	endtask

	// set pointer, repeated start, read n bytes, last one refused
	task automatic rd(input logic [7:0] cmd, input int n);
		int k;
		for (k = 0; wr_valid !== 1'b0 && k < T; k++)
			@(negedge ref_clk);
		tmo(k);
		wr(cmd, 0, 1'b0);
		op(2'h0, {dev, 1'b1}, 1'b0);
		`chk(nak, 1'b0)
		for (k = 0; k < n; k++) begin
			op(2'h2, 8'h00, k == n - 1);
			`chk(got, mdl[ptr])
			ptr = nxt(ptr);
		end
		op(2'h3, 8'h00, 1'b0);
		`chk(rd_addr, ptr)
	endtask

	// Main sequence
	initial begin
		void'($urandom(32'h0ea810a0));
		for (int i = 0; i < 256; i++) begin
			regs[i] = 8'($urandom);
			mdl[i] = regs[i];
		end
		repeat (20) @(negedge ref_clk);
		reset_n = 1'b1;
		repeat (2) @(negedge ref_clk);
		`chk(rd_addr, 8'h00)
		// every tie pattern: a near miss is refused, its own address taken
		for (int i = 0; i < 64; i++) begin
			{p3, p2, p1} = 6'(i);
			dev = dec(p1, p2, p3);
			repeat (4) @(negedge ref_clk);
			op(2'h0, {dev ^ 7'(1 << (i % 7)), 1'b0}, 1'b0);
			`chk(nak, 1'b1)
			op(2'h0, {dev, 1'b0}, 1'b0);
			`chk(nak, 1'b0)
			op(2'h3, 8'h00, 1'b0);
		end
		{p3, p2, p1} = 6'($urandom);
		dev = dec(p1, p2, p3);
		repeat (4) @(negedge ref_clk);
		wr(8'h11, 0, 1'b1);
		`chk(wr_valid, 1'b0)
		foreach (starts[j])
			wr(starts[j], 3, 1'b1);
		// drain stalled: buffer fills and the bus is held
		@(posedge ref_clk);
		stall = 1'b1;
		fork
			begin
				repeat (5700) @(posedge ref_clk);
				stall = 1'b0;
			end
		join_none
		wr(8'h10, 18, 1'b1);
		wr(8'h06, 2, 1'b1);
		foreach (starts[j])
			rd(starts[j], 3);
		end_of_test();
	end
endmodule
